//--- hw/xma_pkg.sv
// Purpose: shared constants and types for the far-memory alu datapath
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   register offsets are byte addresses
package xma_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] XMA_OFS_CMD      = 8'h00;
  localparam logic [7:0] XMA_OFS_WORK     = 8'h04;
  localparam logic [7:0] XMA_OFS_STATUS   = 8'h08;
  localparam logic [7:0] XMA_OFS_MEM_ADDR = 8'h0C;
  localparam logic [7:0] XMA_OFS_MEM_DATA = 8'h10;

  // command word fields
  localparam int XMA_CMD_OP_LSB   = 0;
  localparam int XMA_CMD_BIT_LSB  = 5;
  localparam int XMA_CMD_ADDR_LSB = 8;

  // status word fields
  localparam int XMA_ST_BUSY_BIT = 6;
  localparam int XMA_ST_SKIP_BIT = 7;

  // reset values
  localparam logic [7:0] XMA_WORK_RST  = 8'h00;
  localparam logic [5:0] XMA_FLAGS_RST = 6'h00;
  localparam logic [7:0] XMA_ALL_ONES  = 8'hFF;
  localparam logic [7:0] XMA_ZERO      = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    XMA_FAR_MOVE, XMA_FAR_MOVE_TO_MEMORY, XMA_FAR_BITWISE_OR, XMA_FAR_OR_TO_MEMORY,
    XMA_FAR_ROTATE_LEFT, XMA_FAR_ROTATE_LEFT_TO_WORKING,
    XMA_FAR_ROTATE_LEFT_THROUGH_CARRY, XMA_FAR_ROTATE_LEFT_CARRY_TO_WORKING,
    XMA_FAR_ROTATE_RIGHT, XMA_FAR_ROTATE_RIGHT_TO_WORKING,
    XMA_FAR_ROTATE_RIGHT_THROUGH_CARRY, XMA_FAR_ROTATE_RIGHT_CARRY_TO_WORKING,
    XMA_FAR_SUBTRACT_BORROW, XMA_FAR_SUBTRACT_BORROW_TO_MEMORY,
    XMA_FAR_SUBTRACT, XMA_FAR_SUBTRACT_TO_MEMORY,
    XMA_FAR_DECREMENT_SKIP_ZERO, XMA_FAR_DECREMENT_SKIP_ZERO_TO_WORKING,
    XMA_FAR_INCREMENT_SKIP_ZERO, XMA_FAR_INCREMENT_SKIP_ZERO_TO_WORKING,
    XMA_FAR_SET_ONES, XMA_FAR_SET_BIT, XMA_FAR_SKIP_NONZERO, XMA_FAR_SKIP_BIT_NONZERO,
    XMA_FAR_NIBBLE_EXCHANGE
  } xma_op_t;

  // flag bits, packed msb first: cz sc ov ac z c -> bits 5..0
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_result_flag;
    logic signed_wrap_flag;
    logic nibble_carry_flag;
    logic zero;
    logic carry;
  } xma_flags_t;

  typedef enum logic [1:0] {XMA_IDLE, XMA_EXEC, XMA_DUMMY} xma_state_t;

endpackage

//--- hw/xma_core.sv
// Purpose: executes far-memory single operand and working register instructions
// Assumes: software issues one instruction at a time over apb, memory lives here
// Notes:   a taken skip stretches the instruction by one dummy cycle
//
// How it works
// - full address reaches any memory byte directly
// - far move loads working register, flags untouched
// - move to memory stores working register, no flags
// - or of working and memory, zero only
// - left rotate, bit 7 into bit 0
// - left through carry, bit 7 to carry
// - right rotate, bit 0 into bit 7
// - right through carry, bit 0 to carry
// - working variants leave memory unchanged
// - subtract with borrow updates six flags
// - carry set when result not negative
// - plain subtract, same six flags
// - decrement memory, skip when zero
// - increment memory, skip when zero
// - working variants skip on working result zero
// - taken skip adds one dummy cycle
// - set byte writes all ones
// - set bit forces one bit high
// - skip when memory byte nonzero
// - skip when selected bit nonzero
// - nibble exchange swaps memory halves
`timescale 1ns/100ps
module xma_core
  import xma_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             busy,
  output logic             skip_taken
);

  localparam int DEPTH = 1 << ADDR_W;

  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  logic [7:0]        data_mem [DEPTH];
  logic [7:0]        work;
  xma_flags_t        flags;
  xma_state_t        state;
  logic              skip_seen;
  logic [ADDR_W-1:0] mem_ptr;
  xma_op_t           cmd_op;
  logic [2:0]        cmd_bit;
  logic [ADDR_W-1:0] cmd_addr;

  // apb decode
  logic       acc_edge;
  logic       wr_edge;
  logic       map_hit;
  logic       wr_refused;
  logic [7:0] pw8;
  assign acc_edge   = psel && penable && pready;
  assign wr_edge    = acc_edge && pwrite && !pslverr;
  assign pw8        = pwdata[7:0];
  assign map_hit    = (paddr == XMA_OFS_CMD) || (paddr == XMA_OFS_WORK) || (paddr == XMA_OFS_STATUS) ||
                      (paddr == XMA_OFS_MEM_ADDR) || (paddr == XMA_OFS_MEM_DATA);
  // writes during execution would race the datapath, so they are refused
  assign wr_refused = pwrite && (state != XMA_IDLE);

  // ---------------------------------------------------------------
  // apb slave: answer registered at setup, one wait-free access
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (!map_hit || wr_refused);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          XMA_OFS_WORK:     prdata <= {24'h00_0000, work};
          XMA_OFS_STATUS:   prdata <= {24'h00_0000, skip_seen, state != XMA_IDLE, flags};
          XMA_OFS_MEM_ADDR: prdata <= 32'(mem_ptr);
          XMA_OFS_MEM_DATA: prdata <= {24'h00_0000, data_mem[mem_ptr]};
          XMA_OFS_CMD:      prdata <= 32'({cmd_addr, cmd_bit, 5'(cmd_op)});
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  logic [7:0] opnd;
  logic [7:0] next_work;
  logic [7:0] next_mem;
  logic       mem_we;
  logic       work_we;
  xma_flags_t next_flags;
  logic       next_skip;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic       borrow;
  logic [7:0] res;

  assign opnd = data_mem[cmd_addr];

  always_comb begin
    next_work  = work;
    next_mem   = opnd;
    mem_we     = 1'b0;
    work_we    = 1'b0;
    next_flags = flags;
    next_skip  = 1'b0;
    res        = XMA_ZERO;
    // borrow-in only for the with-borrow forms; carry is an inverted borrow
    borrow     = (cmd_op == XMA_FAR_SUBTRACT_BORROW || cmd_op == XMA_FAR_SUBTRACT_BORROW_TO_MEMORY) ?
                 !flags.carry : 1'b0;
    diff       = {1'b0, work} - {1'b0, opnd} - {8'h00, borrow};
    ndiff      = {1'b0, work[3:0]} - {1'b0, opnd[3:0]} - {4'h0, borrow};
    case (cmd_op)
      XMA_FAR_MOVE: begin
        next_work = opnd;
        work_we   = 1'b1;
      end
      XMA_FAR_MOVE_TO_MEMORY: begin
        next_mem = work;
        mem_we   = 1'b1;
      end
      XMA_FAR_BITWISE_OR, XMA_FAR_OR_TO_MEMORY: begin
        res             = work | opnd;
        next_flags.zero = (res == XMA_ZERO);
        next_work       = res;
        next_mem        = res;
        work_we         = (cmd_op == XMA_FAR_BITWISE_OR);
        mem_we          = (cmd_op == XMA_FAR_OR_TO_MEMORY);
      end
      XMA_FAR_ROTATE_LEFT, XMA_FAR_ROTATE_LEFT_TO_WORKING: begin
        res       = {opnd[6:0], opnd[7]};
        next_work = res;
        next_mem  = res;
        work_we   = (cmd_op == XMA_FAR_ROTATE_LEFT_TO_WORKING);
        mem_we    = (cmd_op == XMA_FAR_ROTATE_LEFT);
      end
      XMA_FAR_ROTATE_LEFT_THROUGH_CARRY, XMA_FAR_ROTATE_LEFT_CARRY_TO_WORKING: begin
        res              = {opnd[6:0], flags.carry};
        next_flags.carry = opnd[7];
        next_work        = res;
        next_mem         = res;
        work_we          = (cmd_op == XMA_FAR_ROTATE_LEFT_CARRY_TO_WORKING);
        mem_we           = (cmd_op == XMA_FAR_ROTATE_LEFT_THROUGH_CARRY);
      end
      XMA_FAR_ROTATE_RIGHT, XMA_FAR_ROTATE_RIGHT_TO_WORKING: begin
        res       = {opnd[0], opnd[7:1]};
        next_work = res;
        next_mem  = res;
        work_we   = (cmd_op == XMA_FAR_ROTATE_RIGHT_TO_WORKING);
        mem_we    = (cmd_op == XMA_FAR_ROTATE_RIGHT);
      end
      XMA_FAR_ROTATE_RIGHT_THROUGH_CARRY, XMA_FAR_ROTATE_RIGHT_CARRY_TO_WORKING: begin
        res              = {flags.carry, opnd[7:1]};
        next_flags.carry = opnd[0];
        next_work        = res;
        next_mem         = res;
        work_we          = (cmd_op == XMA_FAR_ROTATE_RIGHT_CARRY_TO_WORKING);
        mem_we           = (cmd_op == XMA_FAR_ROTATE_RIGHT_THROUGH_CARRY);
      end
      XMA_FAR_SUBTRACT_BORROW, XMA_FAR_SUBTRACT_BORROW_TO_MEMORY,
      XMA_FAR_SUBTRACT, XMA_FAR_SUBTRACT_TO_MEMORY: begin
        res                           = diff[7:0];
        next_flags.carry              = !diff[8];
        next_flags.nibble_carry_flag  = !ndiff[4];
        next_flags.zero               = (res == XMA_ZERO);
        next_flags.signed_wrap_flag   = (work[7] ^ opnd[7]) & (work[7] ^ res[7]);
        next_flags.signed_result_flag = next_flags.signed_wrap_flag ^ res[7];
        // chained zero carries the zero history through multi-byte borrow chains
        next_flags.chained_zero_flag  = (cmd_op == XMA_FAR_SUBTRACT || cmd_op == XMA_FAR_SUBTRACT_TO_MEMORY) ?
                                        (res == XMA_ZERO) : ((res == XMA_ZERO) && flags.chained_zero_flag);
        next_work                     = res;
        next_mem                      = res;
        work_we = (cmd_op == XMA_FAR_SUBTRACT_BORROW || cmd_op == XMA_FAR_SUBTRACT);
        mem_we  = !work_we;
      end
      XMA_FAR_DECREMENT_SKIP_ZERO, XMA_FAR_DECREMENT_SKIP_ZERO_TO_WORKING: begin
        res       = opnd - 8'h01;
        next_skip = (res == XMA_ZERO);
        next_work = res;
        next_mem  = res;
        work_we   = (cmd_op == XMA_FAR_DECREMENT_SKIP_ZERO_TO_WORKING);
        mem_we    = !work_we;
      end
      XMA_FAR_INCREMENT_SKIP_ZERO, XMA_FAR_INCREMENT_SKIP_ZERO_TO_WORKING: begin
        res       = opnd + 8'h01;
        next_skip = (res == XMA_ZERO);
        next_work = res;
        next_mem  = res;
        work_we   = (cmd_op == XMA_FAR_INCREMENT_SKIP_ZERO_TO_WORKING);
        mem_we    = !work_we;
      end
      XMA_FAR_SET_ONES: begin
        next_mem = XMA_ALL_ONES;
        mem_we   = 1'b1;
      end
      XMA_FAR_SET_BIT: begin
        next_mem          = opnd;
        next_mem[cmd_bit] = 1'b1;
        mem_we            = 1'b1;
      end
      XMA_FAR_SKIP_NONZERO:     next_skip = (opnd != XMA_ZERO);
      XMA_FAR_SKIP_BIT_NONZERO: next_skip = opnd[cmd_bit];
      XMA_FAR_NIBBLE_EXCHANGE: begin
        next_mem = {opnd[3:0], opnd[7:4]};
        mem_we   = 1'b1;
      end
      default: begin
        next_skip = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer: idle, execute, optional dummy cycle
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state      <= XMA_IDLE;
      busy       <= 1'b0;
      skip_taken <= 1'b0;
    end else begin
      skip_taken <= 1'b0;
      case (state)
        XMA_IDLE: begin
          if (wr_edge && paddr == XMA_OFS_CMD) begin
            state <= XMA_EXEC;
            busy  <= 1'b1;
          end
        end
        XMA_EXEC: begin
          if (next_skip) begin
            state      <= XMA_DUMMY;
            skip_taken <= 1'b1;
          end else begin
            state <= XMA_IDLE;
            busy  <= 1'b0;
          end
        end
        XMA_DUMMY: begin
          state <= XMA_IDLE;
          busy  <= 1'b0;
        end
        default: begin
          state <= XMA_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // command latch
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cmd_op   <= XMA_FAR_MOVE;
      cmd_bit  <= 3'h0;
      cmd_addr <= '0;
    end else if (wr_edge && paddr == XMA_OFS_CMD) begin
      cmd_op   <= xma_op_t'(pwdata[XMA_CMD_OP_LSB +: 5]);
      cmd_bit  <= pwdata[XMA_CMD_BIT_LSB +: 3];
      cmd_addr <= pwdata[XMA_CMD_ADDR_LSB +: ADDR_W];
    end
  end

  // working register and flags: software writes only while idle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      work  <= XMA_WORK_RST;
      flags <= xma_flags_t'(XMA_FLAGS_RST);
    end else if (state == XMA_EXEC) begin
      if (work_we) begin
        work <= next_work;
      end
      flags <= next_flags;
    end else if (wr_edge && paddr == XMA_OFS_WORK) begin
      work <= pw8;
    end else if (wr_edge && paddr == XMA_OFS_STATUS) begin
      flags <= xma_flags_t'(pw8[5:0]);
    end
  end

  // sticky skip flag; a new skip wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      skip_seen <= 1'b0;
    end else if (state == XMA_EXEC && next_skip) begin
      skip_seen <= 1'b1;
    end else if (wr_edge && paddr == XMA_OFS_STATUS && pw8[XMA_ST_SKIP_BIT]) begin
      skip_seen <= 1'b0;
    end
  end

  // memory pointer for software access
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mem_ptr <= '0;
    end else if (wr_edge && paddr == XMA_OFS_MEM_ADDR) begin
      mem_ptr <= pwdata[ADDR_W-1:0];
    end
  end

  // data memory has no reset, it models plain ram
  always_ff @(posedge sys_clk) begin
    if (state == XMA_EXEC && mem_we) begin
      data_mem[cmd_addr] <= next_mem;
    end else if (wr_edge && paddr == XMA_OFS_MEM_DATA) begin
      data_mem[mem_ptr] <= pw8;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic exec;
  assign exec = (state == XMA_EXEC);

  chk_move_no_flags: assert property (exec && cmd_op == XMA_FAR_MOVE |=>
    work == $past(opnd) && flags == $past(flags))
    else $error("far move wrong");
  chk_store_mem: assert property (exec && cmd_op == XMA_FAR_MOVE_TO_MEMORY |=>
    data_mem[$past(cmd_addr)] == $past(work))
    else $error("move to memory wrong");
  chk_or_zero: assert property (exec && cmd_op == XMA_FAR_BITWISE_OR |=> flags.zero == (work == XMA_ZERO))
    else $error("or zero flag wrong");
  chk_rot_left_carry: assert property (exec && cmd_op == XMA_FAR_ROTATE_LEFT_THROUGH_CARRY |=>
    flags.carry == $past(opnd[7]) && data_mem[$past(cmd_addr)][0] == $past(flags.carry))
    else $error("left carry rotate wrong");
  chk_rot_right_work: assert property (exec && cmd_op == XMA_FAR_ROTATE_RIGHT_TO_WORKING |=>
    work == {$past(opnd[0]), $past(opnd[7:1])} && data_mem[$past(cmd_addr)] == $past(opnd))
    else $error("right rotate to working wrong");
  chk_sub_carry: assert property (exec && cmd_op == XMA_FAR_SUBTRACT |=>
    flags.carry == ($past(work) >= $past(opnd)))
    else $error("subtract carry wrong");
  chk_skip_dummy: assert property (exec && next_skip |=> state == XMA_DUMMY ##1 state == XMA_IDLE && !busy)
    else $error("skip dummy cycle wrong");
  chk_noskip_one: assert property (exec && !next_skip |=> state == XMA_IDLE && !skip_taken)
    else $error("unskipped instruction too long");
  chk_set_ones: assert property (exec && cmd_op == XMA_FAR_SET_ONES |=>
    data_mem[$past(cmd_addr)] == XMA_ALL_ONES)
    else $error("set byte wrong");
  chk_nonzero_skip: assert property (exec && cmd_op == XMA_FAR_SKIP_NONZERO |=>
    skip_taken == ($past(opnd) != XMA_ZERO))
    else $error("nonzero skip wrong");
  chk_swap_nibble: assert property (exec && cmd_op == XMA_FAR_NIBBLE_EXCHANGE |=>
    data_mem[$past(cmd_addr)] == {$past(opnd[3:0]), $past(opnd[7:4])})
    else $error("nibble swap wrong");
  chk_dec_to_work: assert property (exec && cmd_op == XMA_FAR_DECREMENT_SKIP_ZERO_TO_WORKING |=>
    work == 8'($past(opnd) - 8'h01) && data_mem[$past(cmd_addr)] == $past(opnd))
    else $error("decrement to working wrong");
  chk_set_bit: assert property (exec && cmd_op == XMA_FAR_SET_BIT |=>
    data_mem[$past(cmd_addr)][$past(cmd_bit)])
    else $error("set bit wrong");

  cov_skip: cover property (exec && next_skip ##2 state == XMA_IDLE);
  cov_inc_wrap: cover property (exec && cmd_op == XMA_FAR_INCREMENT_SKIP_ZERO && next_skip);
  cov_sub_borrow: cover property (exec && cmd_op == XMA_FAR_SUBTRACT_BORROW && !flags.carry);
  cov_refused: cover property (acc_edge && pslverr && pwrite);

endmodule

//--- bench/tb_xma_core.sv
// Purpose: self-checking bench for the far-memory alu datapath
// Assumes: apb slave answers with pready, one register word per access
// Notes:   expected results come from a bench-side model of each opcode
`timescale 1ns/100ps
module tb_xma_core import xma_pkg::*;;

  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  logic        sys_clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        skip_taken;
  int          num_errors;
  int          samples_checked;

  xma_core #(.ADDR_W(8)) dut (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .busy       (busy),
    .skip_taken (skip_taken)
  );

  // free-running 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // apb master: request held until pready is sampled high
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                     output logic [31:0] rdat, output logic err);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      num_errors++;
      $display("apb transfer never answered");
      final_report();
    end
    rdat = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  // ---------------------------------------------------------------
  // reference model; flags are c z ac ov sc cz from bit 0 up
  // ---------------------------------------------------------------
  function automatic void model(input logic [4:0] op, input logic [2:0] ix, input logic [7:0] w,
                                input logic [7:0] m, input logic [5:0] f, output logic [7:0] ow,
                                output logic [7:0] om, output logic [5:0] of, output logic sk);
    logic [8:0] r;
    logic [4:0] lo;
    logic       bin;
    logic [7:0] t;
    ow = w;
    om = m;
    of = f;
    sk = 1'b0;
    // borrow in is the inverted carry, only for the with-borrow pair
    bin = (op == 5'd12 || op == 5'd13) ? ~f[0] : 1'b0;
    r = {1'b0, w} - {1'b0, m} - {8'h0, bin};
    lo = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
    t = 8'h00;
    case (op)
      5'd0: ow = m;
      5'd1: om = w;
      5'd2, 5'd3: begin
        t = w | m;
        if (op == 5'd2) ow = t; else om = t;
        of[1] = (t == 8'h00);
      end
      5'd4: om = {m[6:0], m[7]};
      5'd5: ow = {m[6:0], m[7]};
      5'd6, 5'd7: begin
        t = {m[6:0], f[0]};
        of[0] = m[7];
        if (op == 5'd6) om = t; else ow = t;
      end
      5'd8: om = {m[0], m[7:1]};
      5'd9: ow = {m[0], m[7:1]};
      5'd10, 5'd11: begin
        t = {f[0], m[7:1]};
        of[0] = m[0];
        if (op == 5'd10) om = t; else ow = t;
      end
      5'd12, 5'd13, 5'd14, 5'd15: begin
        t = r[7:0];
        if (op[0]) om = t; else ow = t;
        of[0] = ~r[8];
        of[1] = (t == 8'h00);
        of[2] = ~lo[4];
        of[3] = (w[7] ^ m[7]) & (w[7] ^ t[7]);
        of[4] = of[3] ^ t[7];
        of[5] = (op < 5'd14) ? (of[1] & f[5]) : of[1];
      end
      5'd16, 5'd17, 5'd18, 5'd19: begin
        t = (op < 5'd18) ? m - 8'h01 : m + 8'h01;
        sk = (t == 8'h00);
        if (op[0]) ow = t; else om = t;
      end
      5'd20: om = 8'hFF;
      5'd21: om[ix] = 1'b1;
      5'd22: sk = (m != 8'h00);
      5'd23: sk = m[ix];
      5'd24: om = {m[3:0], m[7:4]};
      default: ;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // one instruction: load operands, issue, time it, read back
  // ---------------------------------------------------------------
  int test_no;

  task automatic run_op(input logic [4:0] op, input logic [2:0] ix, input logic [7:0] a,
                        input logic [7:0] w, input logic [7:0] m, input logic [5:0] f);
    logic [7:0]  ew;
    logic [7:0]  em;
    logic [5:0]  ef;
    logic        sk;
    logic [31:0] d;
    int          n;
    int          bc;
    int          sc;
    wr(XMA_OFS_MEM_ADDR, {24'h0, a});
    wr(XMA_OFS_MEM_DATA, {24'h0, m});
    wr(XMA_OFS_WORK, {24'h0, w});
    // bit 7 written as one clears the sticky skip record
    wr(XMA_OFS_STATUS, {24'h0, 2'b10, f});
    model(op, ix, w, m, f, ew, em, ef, sk);
    wr(XMA_OFS_CMD, {16'h0, a, ix, op});
    bc = 0;
    sc = 0;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (skip_taken === 1'b1) sc++;
      if (busy === 1'b0) break;
      bc++;
    end
    if (n == 20) begin
      num_errors++;
      $display("instruction never finished");
      final_report();
    end
    check("busy cycles", 32'(bc), 32'(1 + sk));
    check("skip pulses", 32'(sc), {31'h0, sk});
    rd(XMA_OFS_WORK, d);
    check("working register", d, {24'h0, ew});
    rd(XMA_OFS_MEM_DATA, d);
    check("memory byte", d, {24'h0, em});
    rd(XMA_OFS_STATUS, d);
    check("status", d, {24'h0, sk, 1'b0, ef});
    test_no++;
    $display("test %0d op %0d done", test_no, op);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic        e;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    samples_checked = 0;
    test_no = 0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    void'($urandom(32'h9d576928));
    // unmapped offset answers with an error and zero data
    apb(1'b0, 8'h14, 32'h0, d, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", d, 32'h0);
    // a write landing in the dummy cycle of a taken skip is refused and changes nothing
    wr(XMA_OFS_MEM_ADDR, 32'h0000_0030);
    wr(XMA_OFS_MEM_DATA, 32'h0000_0001);
    wr(XMA_OFS_CMD, 32'h0000_3016);
    apb(1'b1, XMA_OFS_WORK, 32'h0000_00A5, d, e);
    check("refused write error", {31'h0, e}, 32'h1);
    rd(XMA_OFS_WORK, d);
    check("refused write data", d, {24'h0, XMA_WORK_RST});
    $display("test 0 refused write done");
    // hand-picked boundaries: counts wrapping to zero, sign edges, bit ends
    run_op(5'd16, 3'd0, 8'h00, 8'h5A, 8'h01, 6'h00);
    run_op(5'd16, 3'd0, 8'hFF, 8'h5A, 8'h00, 6'h3F);
    run_op(5'd17, 3'd0, 8'h80, 8'h33, 8'h01, 6'h00);
    run_op(5'd18, 3'd0, 8'h7F, 8'h00, 8'hFF, 6'h00);
    run_op(5'd19, 3'd0, 8'h01, 8'h12, 8'hFF, 6'h15);
    run_op(5'd14, 3'd0, 8'h20, 8'h05, 8'h05, 6'h00);
    run_op(5'd15, 3'd0, 8'h21, 8'h00, 8'h01, 6'h3F);
    run_op(5'd12, 3'd0, 8'h22, 8'h80, 8'h00, 6'h00);
    run_op(5'd13, 3'd0, 8'h23, 8'h10, 8'h10, 6'h21);
    run_op(5'd22, 3'd0, 8'h24, 8'h00, 8'h00, 6'h00);
    run_op(5'd22, 3'd0, 8'h25, 8'h00, 8'h40, 6'h00);
    run_op(5'd23, 3'd7, 8'h26, 8'h00, 8'h80, 6'h00);
    run_op(5'd23, 3'd0, 8'h27, 8'h00, 8'hFE, 6'h00);
    run_op(5'd21, 3'd3, 8'h28, 8'h00, 8'h00, 6'h2A);
    run_op(5'd2, 3'd0, 8'h29, 8'h00, 8'h00, 6'h00);
    run_op(5'd10, 3'd0, 8'h2A, 8'h00, 8'h00, 6'h01);
    run_op(5'd6, 3'd0, 8'h2B, 8'h00, 8'h80, 6'h00);
    run_op(5'd25, 3'd0, 8'h2C, 8'h11, 8'h22, 6'h00);
    // every opcode once, then random mixes over the whole address range
    for (int i = 0; i < 25 + 120; i++) begin
      run_op((i < 25) ? 5'(i) : 5'($urandom % 25), 3'($urandom), 8'($urandom), 8'($urandom),
             8'($urandom), 6'($urandom));
    end
    final_report();
  end

endmodule
